// ===== verilog/cbec_consts.svh
// Event codes, unit masks and widths for the cache and bus event counter.
`ifndef CBEC_CONSTS_SVH
`define CBEC_CONSTS_SVH
`define CBEC_EV_SPLIT      8'h49
`define CBEC_EV_PRE_MISS   8'h4b
`define CBEC_EV_LOAD_HIT   8'h4c
`define CBEC_EV_L1_PREF    8'h4e
`define CBEC_EV_BUS_OUTST  8'h60
`define CBEC_EV_BUS_HOLD   8'h61
`define CBEC_UM_SPLIT_ST   8'h02
`define CBEC_UM_PRE_NTA    8'h00
`define CBEC_UM_PRE_ALL    8'h01
`define CBEC_UM_PRE_OUTER  8'h02
`define CBEC_UM_LOAD_HIT   8'h00
`define CBEC_UM_L1_PREF    8'h10
`define CBEC_CNT_W         40
`define CBEC_INC_W         4
`define CBEC_HOLD_CYCLES   2
`endif

// ===== verilog/cbec_pkg.sv
// Types for the cache and bus event counter.
`default_nettype none
package cbec_pkg;
  typedef logic [7:0] cbec_code_type;
  typedef enum logic [3:0] {
    CBEC_SEL_NONE,
    CBEC_SEL_SPLIT_ST,
    CBEC_SEL_PRE_NTA,
    CBEC_SEL_PRE_ALL,
    CBEC_SEL_PRE_OUTER,
    CBEC_SEL_LOAD_HIT,
    CBEC_SEL_L1_PREF,
    CBEC_SEL_BUS_OUTST,
    CBEC_SEL_BUS_HOLD
  } cbec_sel_type;
  typedef enum {
    CBEC_HOLD_IDLE,
    CBEC_HOLD_FIRST,
    CBEC_HOLD_SECOND
  } cbec_hold_type;
endpackage : cbec_pkg
`default_nettype wire

// ===== verilog/cbec_hold_detect.sv
// Counts bus-not-ready drives, one per two bus cycles of assertion.
`timescale 1ns/1ns
`default_nettype none
`include "cbec_consts.svh"
module cbec_hold_detect (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic bus_cycle_en_i,
  input  wire logic bus_hold_off_drive_i,
  output var  logic hold_pulse_o
);
  import cbec_pkg::*;
  cbec_hold_type state;
  cbec_hold_type next_state;
  logic          next_pulse;
  always_comb begin
    next_state = state;
    next_pulse = 1'b0;
    if (bus_cycle_en_i) begin
      case (state)
        CBEC_HOLD_IDLE: begin
          if (bus_hold_off_drive_i) next_state = CBEC_HOLD_FIRST;
        end
        CBEC_HOLD_FIRST: begin
          // The count is given on the second bus cycle whether or not not-ready is still asserted.
          next_state = CBEC_HOLD_SECOND;
          next_pulse = 1'b1;
        end
        CBEC_HOLD_SECOND: begin
          next_state = bus_hold_off_drive_i ? CBEC_HOLD_FIRST
                                            : CBEC_HOLD_IDLE;
        end
        default: next_state = CBEC_HOLD_IDLE;
      endcase
    end
  end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state        <= CBEC_HOLD_IDLE;
      hold_pulse_o <= 1'b0;
    end else begin
      state        <= next_state;
      hold_pulse_o <= next_pulse;
    end
  end
endmodule : cbec_hold_detect
`default_nettype wire

// ===== verilog/cbec_counter.sv
// Event selection and accumulating counter for cache and bus events.
//
// Behaviour
// - Count stores that straddle two cache lines.
// - Count non-temporal prefetches missing every cache.
// - Count all-level prefetches missing every cache.
// - Count second-level prefetches, both variants, missing.
// - Count prefetch misses at execution, speculative included.
// - Count loads hitting an unfinished prefetch line.
// - Count level-one data prefetch requests issued.
// - Rejected prefetch requests are counted as well.
// - Add pending full-line bus reads every cycle.
// - Read pending from issue until line received.
// - Only cacheable full-line data reads are pending.
// - Count bus-not-ready assertions driven by this processor; the code counts the synchronised bus-pin level, whichever agent drives it.
// - Agents assert not-ready near transaction capacity.
// - One count per two bus cycles asserted.
// - No new transaction while not-ready asserted.
`timescale 1ns/1ns
`default_nettype none
`include "cbec_consts.svh"
module cbec_counter (
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     enable_i,
  input  wire cbec_pkg::cbec_code_type  event_num_i,
  input  wire cbec_pkg::cbec_code_type  unit_mask_i,
  input  wire logic                     clear_i,
  input  wire logic [1:0]               split_line_store_event_i,
  input  wire logic [1:0]               nontemporal_prefetch_miss_event_i,
  input  wire logic [1:0]               all_level_prefetch_miss_event_i,
  input  wire logic [1:0]               second_level_prefetch_a_miss_i,
  input  wire logic [1:0]               second_level_prefetch_b_miss_i,
  input  wire logic [1:0]               load_hit_prefetch_i,
  input  wire logic [1:0]               first_level_prefetch_request_event_i,
  input  wire logic                     bus_read_issue_i,
  input  wire logic                     bus_read_done_i,
  input  wire logic                     bus_read_full_line_i,
  input  wire logic                     bus_read_cacheable_i,
  input  wire logic                     bus_read_data_source_i,
  input  wire logic                     bus_read_done_tracked_i,
  input  wire logic                     bus_cycle_en_i,
  input  wire logic                     bus_not_ready_signal_i,
  output var  logic [`CBEC_CNT_W-1:0]   count_o,
  output var  logic [`CBEC_INC_W-1:0]   outstanding_o,
  output var  logic                     issue_blocked_o
);
  import cbec_pkg::*;

  cbec_sel_type            sel;
  logic [`CBEC_INC_W-1:0]  inc;
  logic                    hold_pulse;
  logic                    bnr_s1;
  logic                    bnr_s2;
  logic                    bnr_s3;
  logic                    bnr_level;
  logic                    issue_tracked;
  logic [`CBEC_INC_W-1:0]  next_outstanding;
  logic [`CBEC_CNT_W-1:0]  next_count;
  wire  logic [2:0]        outer_sum;

  // Exact decode except 8'h60 and 8'h61, which ignore the unit mask; any other pair maps to no selection.
  assign sel =
    (event_num_i == `CBEC_EV_SPLIT && unit_mask_i == `CBEC_UM_SPLIT_ST)
      ? CBEC_SEL_SPLIT_ST :
    (event_num_i == `CBEC_EV_PRE_MISS && unit_mask_i == `CBEC_UM_PRE_NTA)
      ? CBEC_SEL_PRE_NTA :
    (event_num_i == `CBEC_EV_PRE_MISS && unit_mask_i == `CBEC_UM_PRE_ALL)
      ? CBEC_SEL_PRE_ALL :
    (event_num_i == `CBEC_EV_PRE_MISS && unit_mask_i == `CBEC_UM_PRE_OUTER)
      ? CBEC_SEL_PRE_OUTER :
    (event_num_i == `CBEC_EV_LOAD_HIT && unit_mask_i == `CBEC_UM_LOAD_HIT)
      ? CBEC_SEL_LOAD_HIT :
    (event_num_i == `CBEC_EV_L1_PREF && unit_mask_i == `CBEC_UM_L1_PREF)
      ? CBEC_SEL_L1_PREF :
    (event_num_i == `CBEC_EV_BUS_OUTST) ? CBEC_SEL_BUS_OUTST :
    (event_num_i == `CBEC_EV_BUS_HOLD)  ? CBEC_SEL_BUS_HOLD :
    CBEC_SEL_NONE;

  // Both outer-level variants feed one event.
  assign outer_sum = {1'b0, second_level_prefetch_a_miss_i}
                   + {1'b0, second_level_prefetch_b_miss_i};

  // Only cacheable full-line data-cache or prefetcher reads tracked.
  assign issue_tracked = bus_read_issue_i && bus_read_full_line_i
                      && bus_read_cacheable_i && bus_read_data_source_i;

  // Pending from the cycle after issue through the cycle the full line arrives.
  always_comb begin
    next_outstanding = outstanding_o;
    if (issue_tracked && !(bus_read_done_i && bus_read_done_tracked_i)) begin
      next_outstanding = outstanding_o + 1'b1;
    end else if (!issue_tracked && bus_read_done_i
                 && bus_read_done_tracked_i && outstanding_o != '0) begin
      next_outstanding = outstanding_o - 1'b1;
    end
  end

  // Not-ready comes from the bus pins, so it is synchronised first.
  // The filtered level is the registered hold-off output itself.
  assign bnr_level = issue_blocked_o;

  cbec_hold_detect u_hold (
    .ref_clk_i            (ref_clk_i),
    .reset_i              (reset_i),
    .bus_cycle_en_i       (bus_cycle_en_i),
    .bus_hold_off_drive_i (bnr_level),
    .hold_pulse_o         (hold_pulse)
  );

  // Prefetch events arrive at execute, before retirement is known.
  always_comb begin
    inc = '0;
    case (sel)
      CBEC_SEL_SPLIT_ST:  inc = {2'b00, split_line_store_event_i};
      CBEC_SEL_PRE_NTA:   inc = {2'b00,
                                 nontemporal_prefetch_miss_event_i};
      CBEC_SEL_PRE_ALL:   inc = {2'b00,
                                 all_level_prefetch_miss_event_i};
      CBEC_SEL_PRE_OUTER: inc = {1'b0, outer_sum};
      CBEC_SEL_LOAD_HIT:  inc = {2'b00, load_hit_prefetch_i};
      // Rejected requests are already in the request strobe.
      CBEC_SEL_L1_PREF:   inc = {2'b00,
                                 first_level_prefetch_request_event_i};
      CBEC_SEL_BUS_OUTST: inc = outstanding_o;
      CBEC_SEL_BUS_HOLD:  inc = {3'b000, hold_pulse};
      default:            inc = '0;
    endcase
  end

  // Several occurrences in one core cycle add together.
  assign next_count = clear_i ? '0
                    : enable_i ? count_o + {{(`CBEC_CNT_W-`CBEC_INC_W){1'b0}},
                                            inc}
                    : count_o;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bnr_s1 <= 1'b0;
      bnr_s2 <= 1'b0;
      bnr_s3 <= 1'b0;
    end else begin
      bnr_s1 <= bus_not_ready_signal_i;
      bnr_s2 <= bnr_s1;
      bnr_s3 <= bnr_s2;
    end
  end

  // Asserted near capacity, so issuing must stop while it holds.
  // A pin change counts only once the last two stages agree, which keeps
  // a metastable first stage from toggling the level.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      issue_blocked_o <= 1'b0;
    end else if (bnr_s2 == bnr_s3) begin
      issue_blocked_o <= bnr_s3;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_o       <= '0;
      outstanding_o <= '0;
    end else begin
      count_o       <= next_count;
      outstanding_o <= next_outstanding;
    end
  end
endmodule : cbec_counter
`default_nettype wire

// ===== testbench/cbec_counter_props.sv
// Port checker for the cache and bus event counter.
`timescale 1ns/1ns
`default_nettype none
`include "cbec_consts.svh"
module cbec_counter_chk (
  input wire logic                    ref_clk_i,
  input wire logic                    reset_i,
  input wire logic                    enable_i,
  input wire logic                    clear_i,
  input wire cbec_pkg::cbec_code_type event_num_i,
  input wire cbec_pkg::cbec_code_type unit_mask_i,
  input wire logic [1:0]              split_line_store_event_i,
  input wire logic [1:0]              second_level_prefetch_a_miss_i,
  input wire logic [1:0]              second_level_prefetch_b_miss_i,
  input wire logic                    bus_read_issue_i,
  input wire logic                    bus_read_done_i,
  input wire logic                    bus_read_full_line_i,
  input wire logic                    bus_read_cacheable_i,
  input wire logic                    bus_read_data_source_i,
  input wire logic                    bus_not_ready_signal_i,
  input wire logic [`CBEC_CNT_W-1:0]  count_o,
  input wire logic [`CBEC_INC_W-1:0]  outstanding_o,
  input wire logic                    issue_blocked_o
);
  import cbec_pkg::*;
  wire logic [7:0] ev = event_num_i;
  wire logic [7:0] um = unit_mask_i;
  wire logic run = enable_i && !clear_i;
  wire logic trk = bus_read_full_line_i && bus_read_cacheable_i
                   && bus_read_data_source_i;
  wire logic known = (ev == 8'h49 && um == 8'h02)
    || (ev == 8'h4b && um < 8'h03)
    || (ev == 8'h4c && um == 8'h00) || (ev == 8'h4e && um == 8'h10)
    || ev == 8'h60 || ev == 8'h61;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_clear_zeroes: assert property (clear_i |=> count_o == '0)
    else $error("count not cleared");
  a_idle_holds: assert property (!clear_i && (!enable_i || !known)
    |=> $stable(count_o)) else $error("count moved while idle");
  a_split_adds: assert property (run && ev == 8'h49 && um == 8'h02
    |=> count_o == $past(count_o) + $past(split_line_store_event_i))
    else $error("split store sum wrong");
  a_outer_sums: assert property (run && ev == 8'h4b && um == 8'h02
    |=> count_o == $past(count_o) + $past(second_level_prefetch_a_miss_i)
    + $past(second_level_prefetch_b_miss_i)) else $error("outer sum wrong");
  a_occupancy_adds: assert property (run && ev == 8'h60
    |=> count_o == $past(count_o) + $past(outstanding_o))
    else $error("occupancy sum wrong");
  a_track_up: assert property (bus_read_issue_i && trk
    && !bus_read_done_i && outstanding_o < 4'hf
    |=> outstanding_o == $past(outstanding_o) + 4'h1)
    else $error("tracked read not added");
  a_untracked_skip: assert property (bus_read_issue_i && !trk
    && !bus_read_done_i |=> $stable(outstanding_o))
    else $error("untracked read counted");
  a_hold_single: assert property (run && ev == 8'h61
    |=> count_o - $past(count_o) <= 1) else $error("hold count jumped");
  a_blocked_follows: assert property (bus_not_ready_signal_i [*5]
    |=> issue_blocked_o) else $error("not-ready not reflected");
endmodule : cbec_counter_chk
bind cbec_counter cbec_counter_chk u_chk (.ref_clk_i, .reset_i, .enable_i,
  .clear_i, .event_num_i, .unit_mask_i, .split_line_store_event_i,
  .second_level_prefetch_a_miss_i, .second_level_prefetch_b_miss_i,
  .bus_read_issue_i, .bus_read_done_i, .bus_read_full_line_i,
  .bus_read_cacheable_i, .bus_read_data_source_i, .bus_not_ready_signal_i,
  .count_o, .outstanding_o, .issue_blocked_o);
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the cache and bus event counter.
`timescale 1ns/1ns
`default_nettype none
`include "cbec_consts.svh"
module testbench;
  import cbec_pkg::*;
  logic ref_clk_i = 0, reset_i = 1, enable_i = 0, clear_i = 0;
  cbec_code_type ev = 0, um = 0;
  logic [1:0] occ [7];
  logic iss = 0, done = 0, fl = 0, ca = 0, ds = 0, dt = 0, tick = 0, bus_not_ready_signal = 0;
  logic [`CBEC_CNT_W-1:0] count_o;
  logic [`CBEC_INC_W-1:0] outstanding_o;
  logic issue_blocked_o;
  int failures = 0, checks_done = 0, mo = 0;
  longint mcnt = 0;
  logic [15:0] tbl [12] = '{16'h4902, 16'h4b00, 16'h4b01, 16'h4b02, 16'h4c00,
    16'h4e10, 16'h6000, 16'h60a5, 16'h6100, 16'h4901, 16'h4b03, 16'h0000};
  always #50 ref_clk_i = ~ref_clk_i;
  cbec_counter DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .enable_i(enable_i), .event_num_i(ev), .unit_mask_i(um),
    .clear_i(clear_i), .split_line_store_event_i(occ[0]),
    .nontemporal_prefetch_miss_event_i(occ[1]),
    .all_level_prefetch_miss_event_i(occ[2]),
    .second_level_prefetch_a_miss_i(occ[3]),
    .second_level_prefetch_b_miss_i(occ[4]), .load_hit_prefetch_i(occ[5]),
    .first_level_prefetch_request_event_i(occ[6]), .bus_read_issue_i(iss),
    .bus_read_done_i(done), .bus_read_full_line_i(fl),
    .bus_read_cacheable_i(ca), .bus_read_data_source_i(ds),
    .bus_read_done_tracked_i(dt), .bus_cycle_en_i(tick),
    .bus_not_ready_signal_i(bus_not_ready_signal), .count_o(count_o),
    .outstanding_o(outstanding_o), .issue_blocked_o(issue_blocked_o));
  task automatic chk_cnt(input logic [39:0] got, input longint exp);
    checks_done++;
    if (got !== 40'(exp)) begin
      failures++;
      $display("CHECK FAILED %0t count %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt
  task automatic chk_lvl(input logic [3:0] got, input int exp);
    checks_done++;
    if (got !== 4'(exp)) begin
      failures++;
      $display("CHECK FAILED %0t level %h expected %0d", $time, got, exp);
    end
  endtask : chk_lvl
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d failures", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Model update uses the inputs held through the edge, then compares.
  task automatic cyc();
    int inc;
    @(posedge ref_clk_i);
    inc = 0;
    if (ev == 8'h49 && um == 8'h02) inc = occ[0];
    if (ev == 8'h4b && um == 8'h00) inc = occ[1];
    if (ev == 8'h4b && um == 8'h01) inc = occ[2];
    if (ev == 8'h4b && um == 8'h02) inc = occ[3] + occ[4];
    if (ev == 8'h4c && um == 8'h00) inc = occ[5];
    if (ev == 8'h4e && um == 8'h10) inc = occ[6];
    if (ev == 8'h60) inc = mo;
    if (clear_i) mcnt = 0;
    else if (enable_i) mcnt += inc;
    if (iss && fl && ca && ds && !(done && dt)) mo++;
    else if (done && dt && !(iss && fl && ca && ds) && mo > 0) mo--;
    #5;
    if (ev != 8'h61) chk_cnt(count_o, mcnt);
    chk_lvl(outstanding_o, mo);
    #5;
  endtask : cyc
  task automatic rnd();
    foreach (occ[i]) occ[i] = 2'($urandom);
    enable_i = ($urandom % 8) != 0;
    clear_i = ($urandom % 32) == 0;
    iss = (mo < 12) && ($urandom % 2);
    {fl, ca, ds} = ($urandom % 4) ? 3'b111 : 3'($urandom);
    done = 1'($urandom);
    dt = ($urandom % 4) != 0;
    tick = 1'($urandom);
  endtask : rnd
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    foreach (occ[i]) occ[i] = 2'h0;
    void'($urandom(32'h76cb));
    repeat (8) @(posedge ref_clk_i);
    #10 reset_i = 0;
    foreach (tbl[t]) begin
      ev = tbl[t][15:8];
      um = tbl[t][7:0];
      repeat (24) begin
        rnd();
        cyc();
      end
      $display("Test event %h mask %h done", ev, um);
    end
    // Hold-off is held steady so the synchroniser has settled first.
    ev = 8'h61;
    {enable_i, clear_i, iss, done, tick, bus_not_ready_signal} = 6'b100001;
    repeat (5) cyc();
    chk_lvl(issue_blocked_o, 1);
    repeat (4) begin
      tick = 1;
      cyc();
      tick = 0;
      repeat (2) cyc();
    end
    bus_not_ready_signal = 0;
    repeat (6) cyc();
    mcnt += 2;
    chk_cnt(count_o, mcnt);
    chk_lvl(issue_blocked_o, 0);
    $display("Test bus hold-off done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
